/* design/dhp_device.sv */
// device end: two channel register banks behind the strobed parallel port
//
// Contract
// R01 - 3-bit address picks register in selected channel
// R02 - device drives data on reads, samples writes
// R03 - read strobe fall drives addressed byte
// R04 - host captures byte on read strobe rise
// R05 - write strobe rise stores bus byte
// R06 - only the low-selected channel responds
// R07 - channel A control bit drives irq, gp low
// R08 - channel B control bit same behaviour
// R09 - active-low transmit-ready per channel
// R10 - active-low receive-ready per channel
// R11 - tx ready when space, rx ready when data
`timescale 1ns/10ps
module dhp_device
   import dhp_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // host bus
   dhp_if.device           bus,
   // user side: per channel serial core status and events
   input  wire logic [1:0] tx_space,
   input  wire logic [1:0] rx_avail,
   input  wire logic [1:0] irq_req,
   output logic      [1:0] tx_push,
   output logic      [7:0] tx_byte,
   output logic      [1:0] rx_pop
);
   // pin inputs: strobes, selects, address and data all come from the host
   // side, so every one of them passes four flip-flops before it is used
   localparam int NSYNC = 4 + DHP_ADDR_W + DHP_DATA_W;
   // idle levels: strobes and selects high, address and data low
   localparam logic [NSYNC-1:0] SYNC_IDLE = {{(DHP_ADDR_W + DHP_DATA_W){1'b0}}, 4'hF};
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
   assign pin_raw = {bus.data_bus, bus.addr, bus.chan_b_select_n, bus.chan_a_select_n,
                     bus.write_strobe_n, bus.read_strobe_n};

   // first stage feeds only the second; change accepted when 2 and 3 agree
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= SYNC_IDLE;
         sync2_reg <= SYNC_IDLE;
         sync3_reg <= SYNC_IDLE;
         filt_reg  <= SYNC_IDLE;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         for (int i = 0; i < NSYNC; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) filt_reg[i] <= sync3_reg[i];
         end
      end
   end

   // filtered pins; address and data bits settle one by one, so the host
   // must hold them steady for a few cycles on both sides of a strobe edge
   logic                  rd_n, wr_n, rd_n_d_reg, wr_n_d_reg;
   logic [1:0]            sel;
   logic [DHP_ADDR_W-1:0] addr_s;
   logic [DHP_DATA_W-1:0] data_s;
   assign rd_n   = filt_reg[0];
   assign wr_n   = filt_reg[1];
   assign sel    = ~filt_reg[3:2];
   assign addr_s = filt_reg[4 +: DHP_ADDR_W];
   assign data_s = filt_reg[4 + DHP_ADDR_W +: DHP_DATA_W];

   // strobe edge detection on the filtered levels
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_n_d_reg <= 1'b1;
         wr_n_d_reg <= 1'b1;
      end else begin
         rd_n_d_reg <= rd_n;
         wr_n_d_reg <= wr_n;
      end
   end

   logic rd_fall, rd_rise, wr_rise;
   assign rd_fall = rd_n_d_reg & ~rd_n;
   assign rd_rise = ~rd_n_d_reg & rd_n;
   assign wr_rise = ~wr_n_d_reg & wr_n;

   // one-hot channel decode; both selects low means no response
   function automatic logic [1:0] chan_hit(input logic [1:0] s);
      chan_hit = (s == 2'b01 || s == 2'b10) ? s : 2'b00;
   endfunction : chan_hit

   // output-control bit of one channel's modem control register
   function automatic logic out_ctrl(input logic [7:0] mctl);
      out_ctrl = mctl[DHP_OUT_CTRL_BIT];
   endfunction : out_ctrl

   // refuse package settings that the decode cannot serve
   if (DHP_NUM_REGS != (1 << DHP_ADDR_W)) begin : g_bad_depth
      $error("register count must match the address width");
   end
   if (DHP_MODEM_CTRL_ADDR >= DHP_NUM_REGS || DHP_OUT_CTRL_BIT >= DHP_DATA_W) begin : g_bad_ctrl
      $error("output control bit lies outside the register file");
   end
   if (DHP_CHANNELS != 2) begin : g_bad_chan
      $error("one select pin per channel, exactly two channels");
   end

   logic [1:0] hit;
   assign hit = chan_hit(sel); // R06

   // registers of both channels; address taken unlatched from filtered pins at strobe edge
   logic [7:0] regs_reg [DHP_CHANNELS][DHP_NUM_REGS];
   logic [7:0] rd_data_reg;
   logic       rd_oe_reg;
   logic [1:0] tx_push_reg, rx_pop_reg;
   logic [7:0] tx_byte_reg;

   // each bank takes a write only while its own select is low; the store
   // lands several cycles after the strobe rise, hence the host's hold phase
   generate
      for (genvar c = 0; c < DHP_CHANNELS; c++) begin : g_chan
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               for (int r = 0; r < DHP_NUM_REGS; r++) regs_reg[c][r] <= DHP_REG_RESET;
            end else if (wr_rise && hit[c]) begin
               regs_reg[c][addr_s] <= data_s; // R05 R01
            end
         end
      end
   endgenerate

   // read path: drive on strobe fall, release on rise
   // byte is captured once at the fall, so a later store shows next read
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_reg <= 8'h00;
         rd_oe_reg   <= 1'b0;
      end else if (rd_fall && |hit) begin
         rd_data_reg <= regs_reg[hit[1]][addr_s]; // R03 R01
         rd_oe_reg   <= 1'b1; // R02
      end else if (rd_rise || rd_n) begin
         rd_oe_reg   <= 1'b0; // R04
      end
   end

   // queue side effects: write to address 0 pushes, read of 0 pops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_push_reg <= 2'b00;
         rx_pop_reg  <= 2'b00;
         tx_byte_reg <= 8'h00;
      end else begin
         tx_push_reg <= (wr_rise && addr_s == DHP_QUEUE_ADDR) ? hit : 2'b00; // R06
         rx_pop_reg  <= (rd_rise && addr_s == DHP_QUEUE_ADDR) ? hit : 2'b00; // R06
         if (wr_rise) tx_byte_reg <= data_s; // R02
      end
   end

   // control bit both enables the irq driver and pulls gp low; taking
   // both from one bit means the two pins can never disagree
   logic [1:0] irq_reg, irq_oe_reg, gp_n_reg, txr_n_reg, rxr_n_reg;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_oe_reg <= 2'b00;
         gp_n_reg   <= 2'b11;
      end else begin
         for (int c = 0; c < DHP_CHANNELS; c++) begin
            irq_oe_reg[c] <= out_ctrl(regs_reg[c][DHP_MODEM_CTRL_ADDR]); // R07 R08
            gp_n_reg[c]   <= ~out_ctrl(regs_reg[c][DHP_MODEM_CTRL_ADDR]); // R07 R08
         end
      end
   end

   // irq level retimed so the pin comes straight from a flip-flop;
   // costs one cycle of latency on every interrupt
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 2'b00;
      end else begin
         irq_reg <= irq_req;
      end
   end

   // ready pins are active low and lag the core status by one cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txr_n_reg <= 2'b11;
         rxr_n_reg <= 2'b11;
      end else begin
         txr_n_reg <= ~tx_space; // R09 R11
         rxr_n_reg <= ~rx_avail; // R10 R11
      end
   end

   // pins and user outputs straight from their flip-flops
   assign bus.data_d2h          = rd_data_reg;
   assign bus.data_d2h_oe       = rd_oe_reg;
   assign bus.chan_a_irq        = irq_reg[0];
   assign bus.chan_b_irq        = irq_reg[1];
   assign bus.chan_a_irq_oe     = irq_oe_reg[0];
   assign bus.chan_b_irq_oe     = irq_oe_reg[1];
   assign bus.chan_a_gp_out_n   = gp_n_reg[0];
   assign bus.chan_b_gp_out_n   = gp_n_reg[1];
   assign bus.chan_a_tx_ready_n = txr_n_reg[0];
   assign bus.chan_b_tx_ready_n = txr_n_reg[1];
   assign bus.chan_a_rx_ready_n = rxr_n_reg[0];
   assign bus.chan_b_rx_ready_n = rxr_n_reg[1];
   assign tx_push = tx_push_reg;
   assign rx_pop  = rx_pop_reg;
   assign tx_byte = tx_byte_reg;
endmodule : dhp_device

/* design/dhp_pkg.sv */
// package of shared constants and types for the dual channel host bus port
package dhp_pkg;
   localparam int DHP_ADDR_W      = 3;
   localparam int DHP_DATA_W      = 8;
   localparam int DHP_NUM_REGS    = 8;
   localparam int DHP_CHANNELS    = 2;
   // address of the modem control register inside each channel
   localparam logic [2:0] DHP_MODEM_CTRL_ADDR = 3'h4;
   // position of the output-control bit in the modem control register
   localparam int DHP_OUT_CTRL_BIT = 3;
   // address whose accesses also move the channel queues
   localparam logic [2:0] DHP_QUEUE_ADDR = 3'h0;
   // shortest strobe phase that still covers the device's input filter
   localparam int DHP_MIN_STROBE_CYCLES = 8;
   // reset value of every channel register
   localparam logic [7:0] DHP_REG_RESET = 8'h00;
   // host strobe phase lengths in core clocks (5 ns each)
   localparam int DHP_STROBE_NS     = 40;
   localparam int DHP_CLK_NS        = 5;
   localparam int DHP_STROBE_CYCLES = (DHP_STROBE_NS + DHP_CLK_NS - 1) / DHP_CLK_NS;
   // host sequencer states
   typedef enum logic [3:0] {
      DHP_IDLE   = 4'b0001,
      DHP_SETUP  = 4'b0010,
      DHP_STROBE = 4'b0100,
      DHP_HOLD   = 4'b1000
   } dhp_host_state_t;
endpackage : dhp_pkg

/* design/dhp_if.sv */
// interface joining the host end and the device end of the parallel port
`timescale 1ns/10ps
interface dhp_if;
   logic [2:0] addr;
   logic [7:0] data_h2d;
   logic [7:0] data_d2h;
   logic       data_d2h_oe;
   logic       read_strobe_n;
   logic       write_strobe_n;
   logic       chan_a_select_n;
   logic       chan_b_select_n;
   logic       chan_a_irq;
   logic       chan_a_irq_oe;
   logic       chan_b_irq;
   logic       chan_b_irq_oe;
   logic       chan_a_gp_out_n;
   logic       chan_b_gp_out_n;
   logic       chan_a_tx_ready_n;
   logic       chan_a_rx_ready_n;
   logic       chan_b_tx_ready_n;
   logic       chan_b_rx_ready_n;
   // bus level: device wins while it drives, else host data
   logic [7:0] data_bus;
   assign data_bus = data_d2h_oe ? data_d2h : data_h2d;

   modport device (
      input  addr, data_bus, read_strobe_n, write_strobe_n,
      input  chan_a_select_n, chan_b_select_n,
      output data_d2h, data_d2h_oe, chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
      output chan_a_gp_out_n, chan_b_gp_out_n,
      output chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
   );
   modport host (
      output addr, data_h2d, read_strobe_n, write_strobe_n,
      output chan_a_select_n, chan_b_select_n,
      input  data_bus, data_d2h_oe, chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
      input  chan_a_gp_out_n, chan_b_gp_out_n,
      input  chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
   );
endinterface : dhp_if

/* design/dhp_host.sv */
// host end: sequences one strobed read or write per request
`timescale 1ns/10ps
module dhp_host
   import dhp_pkg::*;
#(
   parameter int STROBE_CYCLES = DHP_STROBE_CYCLES
)(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // host bus
   dhp_if.host             bus,
   // user request
   input  wire logic       req_valid,
   input  wire logic       req_write,
   input  wire logic       req_chan,
   input  wire logic [2:0] req_addr,
   input  wire logic [7:0] req_wdata,
   output logic            req_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_rdata
);
   // shorter phases would let the device store after the host moves on;
   // the phase counter is eight bits wide
   if (STROBE_CYCLES < DHP_MIN_STROBE_CYCLES || STROBE_CYCLES > 255) begin : g_bad_strobe
      $error("strobe length out of range");
   end

   dhp_host_state_t st_reg;
   logic [7:0] cnt_reg, rdata_reg, wdata_reg;
   logic [2:0] addr_reg;
   logic       wr_reg, chan_reg, rdn_reg, wrn_reg, csa_reg, csb_reg, rsp_reg, rdy_reg;

   // setup and hold phases give the device's synchronisers time to settle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= DHP_IDLE;
         cnt_reg <= 8'h00;
         addr_reg <= 3'h0;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         chan_reg <= 1'b0;
         rdn_reg <= 1'b1;
         wrn_reg <= 1'b1;
         csa_reg <= 1'b1;
         csb_reg <= 1'b1;
         rsp_reg <= 1'b0;
         rdy_reg <= 1'b1;
      end else begin
         rsp_reg <= 1'b0;
         unique case (st_reg)
            DHP_IDLE: begin
               if (req_valid) begin
                  addr_reg <= req_addr; // R01
                  wdata_reg <= req_wdata;
                  wr_reg <= req_write;
                  chan_reg <= req_chan;
                  csa_reg <= req_chan; // R06
                  csb_reg <= ~req_chan; // R06
                  rdy_reg <= 1'b0;
                  cnt_reg <= 8'(STROBE_CYCLES);
                  st_reg <= DHP_SETUP;
               end
            end
            DHP_SETUP: begin
               if (cnt_reg == 8'h01) begin
                  rdn_reg <= wr_reg;
                  wrn_reg <= ~wr_reg; // R05
                  cnt_reg <= 8'(STROBE_CYCLES);
                  st_reg <= DHP_STROBE;
               end else cnt_reg <= cnt_reg - 8'h01;
            end
            DHP_STROBE: begin
               if (cnt_reg == 8'h01) begin
                  if (!wr_reg) rdata_reg <= bus.data_bus; // R04
                  rdn_reg <= 1'b1;
                  wrn_reg <= 1'b1; // R05
                  cnt_reg <= 8'(STROBE_CYCLES);
                  st_reg <= DHP_HOLD;
               end else cnt_reg <= cnt_reg - 8'h01;
            end
            DHP_HOLD: begin
               if (cnt_reg == 8'h01) begin
                  csa_reg <= 1'b1;
                  csb_reg <= 1'b1;
                  rsp_reg <= 1'b1;
                  rdy_reg <= 1'b1;
                  st_reg <= DHP_IDLE;
               end else cnt_reg <= cnt_reg - 8'h01;
            end
         endcase
      end
   end

   assign bus.addr            = addr_reg;
   assign bus.data_h2d        = wdata_reg;
   assign bus.read_strobe_n   = rdn_reg;
   assign bus.write_strobe_n  = wrn_reg;
   assign bus.chan_a_select_n = csa_reg;
   assign bus.chan_b_select_n = csb_reg;
   assign req_ready = rdy_reg;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;
endmodule : dhp_host

/* verif/dhp_checker.sv */
// concurrent checks on the wires between host end and device end
`timescale 1ns/10ps
module dhp_checker
   import dhp_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // bus wires
   input wire logic [2:0] addr,
   input wire logic [7:0] data_h2d,
   input wire logic       data_d2h_oe,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic       chan_a_select_n,
   input wire logic       chan_b_select_n,
   // output control pins
   input wire logic       chan_a_irq_oe,
   input wire logic       chan_b_irq_oe,
   input wire logic       chan_a_gp_out_n,
   input wire logic       chan_b_gp_out_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // read data must appear within the filter delay of a selected read
   a_read_drive_on: assert property (
      $fell(read_strobe_n) && (chan_a_select_n != chan_b_select_n) |-> ##[1:7] data_d2h_oe)
      else $error("read data not driven");
   a_read_drive_off: assert property (
      $rose(read_strobe_n) |-> ##[1:7] !data_d2h_oe) else $error("bus not released");
   a_drive_in_read: assert property (
      $rose(data_d2h_oe) |-> !read_strobe_n) else $error("drive without read strobe");
   // a write must never meet a driving device
   a_no_drive_write: assert property (
      !write_strobe_n |-> !data_d2h_oe) else $error("bus driven during write");
   a_unselected_quiet: assert property (
      chan_a_select_n && chan_b_select_n |-> !data_d2h_oe) else $error("unselected drive");
   // device stores late, so host must hold address and data after the rise
   a_write_hold: assert property (
      $rose(write_strobe_n) |=> ($stable(addr) && $stable(data_h2d))[*6])
      else $error("write hold broken");
   a_write_width: assert property (
      $fell(write_strobe_n) |-> !write_strobe_n[*8]) else $error("write strobe short");
   a_chan_a_ctrl: assert property (
      chan_a_irq_oe == !chan_a_gp_out_n) else $error("channel a control pins disagree");
   a_chan_b_ctrl: assert property (
      chan_b_irq_oe == !chan_b_gp_out_n) else $error("channel b control pins disagree");
   // a stored control byte must reach the pins within the filter delay
   a_chan_a_follow: assert property (
      $rose(write_strobe_n) && !chan_a_select_n && chan_b_select_n
         && addr == DHP_MODEM_CTRL_ADDR |-> ##[4:7] chan_a_irq_oe == data_h2d[DHP_OUT_CTRL_BIT])
      else $error("channel a control pins not updated");
   a_chan_b_follow: assert property (
      $rose(write_strobe_n) && chan_a_select_n && !chan_b_select_n
         && addr == DHP_MODEM_CTRL_ADDR |-> ##[4:7] chan_b_irq_oe == data_h2d[DHP_OUT_CTRL_BIT])
      else $error("channel b control pins not updated");
   c_read: cover property ($fell(read_strobe_n));
   c_write: cover property ($fell(write_strobe_n));
   c_irq_on: cover property (chan_a_irq_oe && chan_b_irq_oe);
endmodule : dhp_checker

/* verif/tb_dual_uart_host_bus_port.sv */
// testbench joining host end and device end through the port interface
`timescale 1ns/10ps
module tb_dual_uart_host_bus_port;
   import dhp_pkg::*;
   logic       core_clk, rstn, req_valid, req_write, req_chan, req_ready, rsp_valid;
   logic [2:0] req_addr;
   logic [7:0] req_wdata, rsp_rdata, tx_byte, rd;
   logic [1:0] tx_space, rx_avail, irq_req, tx_push, rx_pop;
   int         errors, checked, pushes, pops;
   dhp_if i_dhp_if ();
   dhp_host i_dhp_host (.core_clk(core_clk), .rstn(rstn), .bus(i_dhp_if.host),
      .req_valid(req_valid), .req_write(req_write), .req_chan(req_chan), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata));
   dhp_device i_dhp_device (.core_clk(core_clk), .rstn(rstn), .bus(i_dhp_if.device),
      .tx_space(tx_space), .rx_avail(rx_avail), .irq_req(irq_req), .tx_push(tx_push),
      .tx_byte(tx_byte), .rx_pop(rx_pop));
   dhp_checker i_dhp_checker (.core_clk(core_clk), .rstn(rstn), .addr(i_dhp_if.addr),
      .data_h2d(i_dhp_if.data_h2d), .data_d2h_oe(i_dhp_if.data_d2h_oe),
      .read_strobe_n(i_dhp_if.read_strobe_n), .write_strobe_n(i_dhp_if.write_strobe_n),
      .chan_a_select_n(i_dhp_if.chan_a_select_n), .chan_b_select_n(i_dhp_if.chan_b_select_n),
      .chan_a_irq_oe(i_dhp_if.chan_a_irq_oe), .chan_b_irq_oe(i_dhp_if.chan_b_irq_oe),
      .chan_a_gp_out_n(i_dhp_if.chan_a_gp_out_n), .chan_b_gp_out_n(i_dhp_if.chan_b_gp_out_n));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // count event pulses; a stuck pulse shows up as a wrong total
   always @(posedge core_clk) begin
      pushes += (tx_push[0] === 1'b1) + (tx_push[1] === 1'b1);
      pops += (rx_pop[0] === 1'b1) + (rx_pop[1] === 1'b1);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one host transfer; waits for the answer under a bounded count
   task automatic access(input logic w, input logic ch, input logic [2:0] a,
                         input logic [7:0] wd, output logic [7:0] rdata);
      int n;
      n = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_chan  <= ch;
      req_addr  <= a;
      req_wdata <= wd;
      @(posedge core_clk);
      req_valid <= 1'b0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 100);
      if (n >= 100) errors++;
      chk(req_ready, 1'b1);
      rdata = rsp_rdata;
   endtask : access
   task automatic final_report();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // watchdog well beyond thirty-five transfers of 26 cycles
   initial begin
      #50000;
      errors++;
      final_report();
   end
   initial begin
      {rstn, req_valid, req_write, req_chan, req_addr, req_wdata} = '0;
      {tx_space, rx_avail, irq_req, errors, checked, pushes, pops} = '0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      chk({i_dhp_if.chan_a_gp_out_n, i_dhp_if.chan_b_gp_out_n}, 8'h03);
      chk({i_dhp_if.chan_a_irq_oe, i_dhp_if.chan_b_irq_oe}, 8'h00);
      // distinct patterns per channel expose address or select mixups
      for (int i = 0; i < DHP_NUM_REGS; i++) begin
         access(1'b1, 1'b0, i[2:0], 8'hA0 + i[7:0], rd);
         if (i == 0) chk(tx_byte, 8'hA0);
         access(1'b1, 1'b1, i[2:0], 8'h50 + i[7:0], rd);
      end
      for (int i = 0; i < DHP_NUM_REGS; i++) begin
         access(1'b0, 1'b0, i[2:0], 8'h00, rd);
         chk(rd, 8'hA0 + i[7:0]);
         access(1'b0, 1'b1, i[2:0], 8'h00, rd);
         chk(rd, 8'h50 + i[7:0]);
      end
      chk(pushes[7:0], 8'h02);
      chk(pops[7:0], 8'h02);
      // output-control bit per channel, one at a time
      @(posedge core_clk);
      irq_req <= 2'b11;
      access(1'b1, 1'b0, DHP_MODEM_CTRL_ADDR, 8'h08, rd);
      chk({i_dhp_if.chan_a_gp_out_n, i_dhp_if.chan_a_irq_oe, i_dhp_if.chan_a_irq}, 8'h03);
      chk({i_dhp_if.chan_b_gp_out_n, i_dhp_if.chan_b_irq_oe}, 8'h02);
      access(1'b1, 1'b1, DHP_MODEM_CTRL_ADDR, 8'h08, rd);
      chk({i_dhp_if.chan_b_gp_out_n, i_dhp_if.chan_b_irq_oe, i_dhp_if.chan_b_irq}, 8'h03);
      access(1'b1, 1'b0, DHP_MODEM_CTRL_ADDR, 8'h00, rd);
      chk({i_dhp_if.chan_a_gp_out_n, i_dhp_if.chan_a_irq_oe}, 8'h02);
      // ready pins are active low and per channel
      @(posedge core_clk);
      tx_space <= 2'b10;
      rx_avail <= 2'b01;
      repeat (3) @(posedge core_clk);
      chk({i_dhp_if.chan_a_tx_ready_n, i_dhp_if.chan_b_tx_ready_n}, 8'h02);
      chk({i_dhp_if.chan_a_rx_ready_n, i_dhp_if.chan_b_rx_ready_n}, 8'h01);
      tx_space <= 2'b01;
      rx_avail <= 2'b10;
      repeat (3) @(posedge core_clk);
      chk({i_dhp_if.chan_a_tx_ready_n, i_dhp_if.chan_b_tx_ready_n}, 8'h01);
      chk({i_dhp_if.chan_a_rx_ready_n, i_dhp_if.chan_b_rx_ready_n}, 8'h02);
      final_report();
   end
endmodule : tb_dual_uart_host_bus_port
